/* File: swg_gen.sv */
/*
 * set-point waveform generator: trapezoid, engine-start curve, ramp and
 * arbitrary sequence points, producing a voltage or current set point.
 * assumes all control inputs synchronous to i_clk_sys, times in 0.1 ms ticks.
 */
// What this block does
// - trapezoid runs rise t1, top t2, fall t3, base t4 in order
// - base is offset, top is offset plus amplitude, both kept within nominal
// - trapezoid repeats with period t1+t2+t3+t4 while running
// - engine-start curve drives voltage only, five segments with preloaded defaults
// - each engine-start segment ramps start to end voltage over its time
// - engine-start repeats endless or 1..999 times, pause i_esc_pause between cycles
// - ramp holds start for t1 then moves linearly to end over t2
// - ramp runs once per start and holds the end value
// - ten hours after ramp end the generator stops and zeroes the set point
// - 99 sequence points each with the same parameter set
// - arbitrary block plays start to end index, 1..999 times or endless
// - one sequence block drives only current or only voltage
// - point output is interpolated DC plus interpolated-amplitude-frequency sine
// - both frequencies zero means no sine part
// - sine amplitudes up to half nominal, frequencies up to 10000 Hz
// - sine starts at programmable phase 0..359 degrees
// - DC values lie between sine amplitude and nominal minus amplitude
// - point time 0.1 ms to 36000 s sets the curve duration
// - differing frequencies rejected when change per second is below 9.3
// - any alarm aborts the waveform and switches output off
`include "swg_regs.svh"
module swg_gen
  import swg_pkg::*;
#(
  parameter int AUTOSTOP_TICKS = `SWG_AUTOSTOP_TICKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire swg_mode_t i_mode,
  input wire logic i_target_current,
  input wire logic [15:0] i_nominal,
  input wire logic [15:0] i_static,
  input wire swg_trap_t i_trap,
  input wire swg_ramp_t i_ramp,
  input wire logic [9:0] i_esc_cycles,
  input wire logic [28:0] i_esc_pause,
  input wire logic i_esc_wr,
  input wire logic [2:0] i_esc_idx,
  input wire swg_seg_t i_esc_data,
  input wire logic [6:0] i_arb_start,
  input wire logic [6:0] i_arb_end,
  input wire logic [9:0] i_arb_cycles,
  input wire logic i_pt_wr,
  input wire logic [6:0] i_pt_idx,
  input wire swg_point_t i_pt_data,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_off,
  input wire logic i_alarm,
  output logic [15:0] o_setpoint,
  output logic o_target_current,
  output logic o_output_on,
  output logic o_running,
  output logic o_tick,
  output logic o_wr_reject,
  output logic o_cfg_error
);
  // ==========================================
  // storage and write checks
  swg_point_t pts [`SWG_NUM_PTS];
  swg_seg_t esc [`SWG_NUM_SEGS];
  logic pt_ok;
  logic esc_ok;
  logic [15:0] half_nom;
  logic [13:0] df;
  always_comb begin
    half_nom = {1'b0, i_nominal[15:1]};
    df = (i_pt_data.sine_end_frequency > i_pt_data.sine_start_frequency) ?
         i_pt_data.sine_end_frequency - i_pt_data.sine_start_frequency :
         i_pt_data.sine_start_frequency - i_pt_data.sine_end_frequency;
    pt_ok = i_pt_idx >= 7'h01 && i_pt_idx <= 7'(`SWG_NUM_PTS)
      && i_pt_data.sine_start_amplitude <= half_nom
      && i_pt_data.sine_end_amplitude <= half_nom
      && i_pt_data.sine_start_frequency <= `SWG_FREQ_MAX
      && i_pt_data.sine_end_frequency <= `SWG_FREQ_MAX
      && i_pt_data.angle <= `SWG_ANGLE_MAX
      && i_pt_data.linear_start_value >= i_pt_data.sine_start_amplitude
      && i_pt_data.linear_end_value >= i_pt_data.sine_end_amplitude
      && {1'b0, i_pt_data.linear_start_value} + {1'b0, i_pt_data.sine_start_amplitude}
         <= {1'b0, i_nominal}
      && {1'b0, i_pt_data.linear_end_value} + {1'b0, i_pt_data.sine_end_amplitude}
         <= {1'b0, i_nominal}
      && i_pt_data.time_ticks != 29'h0 && i_pt_data.time_ticks <= `SWG_TIME_MAX
      && (df == 14'h0 || 40'(df) * `SWG_DF_SCALE
          >= `SWG_DF_MIN * 40'(i_pt_data.time_ticks));
    esc_ok = i_esc_idx < 3'(`SWG_NUM_SEGS) && i_esc_data.start_value <= i_nominal
      && i_esc_data.end_value <= i_nominal && i_esc_data.time_ticks != 29'h0
      && i_esc_data.time_ticks <= `SWG_TIME_MAX;
  end
  assign o_wr_reject = (i_pt_wr & ~pt_ok) | (i_esc_wr & ~esc_ok);

  for (genvar g = 0; g < `SWG_NUM_PTS; g++) begin : g_pt
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        pts[g] <= '0;
        pts[g].time_ticks <= `SWG_PT_DEF_TIME;
      end else if (i_pt_wr && pt_ok && i_pt_idx == 7'(g + 1)) begin
        pts[g] <= i_pt_data;
      end
    end
  end

  localparam swg_seg_t ESC_DEF [`SWG_NUM_SEGS] = '{`SWG_ESC_DEF0, `SWG_ESC_DEF1,
    `SWG_ESC_DEF2, `SWG_ESC_DEF3, `SWG_ESC_DEF4};
  for (genvar g = 0; g < `SWG_NUM_SEGS; g++) begin : g_esc
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        esc[g] <= ESC_DEF[g];
      end else if (i_esc_wr && esc_ok && i_esc_idx == 3'(g)) begin
        esc[g] <= i_esc_data;
      end
    end
  end

  // ==========================================
  // 0.1 ms time base
  logic [11:0] tick_cnt_reg;
  logic tick;
  logic tick_d_reg;
  assign tick = tick_cnt_reg == 12'(`SWG_TICK_CYC - 1);
  assign o_tick = tick;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_reg <= 12'h000;
      tick_d_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 12'h000 : tick_cnt_reg + 12'h001;
      tick_d_reg <= tick;
    end
  end

  // ==========================================
  // segment selection
  swg_state_t state_reg;
  logic [6:0] seg_reg;
  logic [28:0] el_reg;
  logic [9:0] cyc_reg;
  logic [28:0] hold_reg;
  logic zero_reg;
  logic on_reg;
  logic tgt_reg;
  swg_point_t pt;
  logic [15:0] seg_s;
  logic [15:0] seg_e;
  logic [28:0] seg_t;
  logic [15:0] off_c;
  logic [15:0] top;
  logic seg_last;
  logic cfg_ok;
  always_comb begin
    off_c = (i_trap.offset > i_nominal) ? i_nominal : i_trap.offset;
    top = off_c + ((i_trap.amplitude > i_nominal - off_c) ?
                   i_nominal - off_c : i_trap.amplitude);
    pt = pts[(seg_reg >= 7'h01 && seg_reg <= 7'(`SWG_NUM_PTS)) ? seg_reg - 7'h01 : 7'h00];
    seg_s = 16'h0000;
    seg_e = 16'h0000;
    seg_t = 29'h0;
    seg_last = 1'b0;
    case (i_mode)
      SWG_MODE_TRAP: begin
        seg_last = seg_reg == 7'h03;
        case (seg_reg[1:0])
          2'h0: begin seg_s = off_c; seg_e = top; seg_t = i_trap.t1; end
          2'h1: begin seg_s = top; seg_e = top; seg_t = i_trap.t2; end
          2'h2: begin seg_s = top; seg_e = off_c; seg_t = i_trap.t3; end
          default: begin seg_s = off_c; seg_e = off_c; seg_t = i_trap.t4; end
        endcase
      end
      SWG_MODE_ESC: begin
        seg_last = seg_reg == 7'(`SWG_NUM_SEGS - 1);
        seg_s = esc[(seg_reg < 7'(`SWG_NUM_SEGS)) ? seg_reg[2:0] : 3'h0].start_value;
        seg_e = esc[(seg_reg < 7'(`SWG_NUM_SEGS)) ? seg_reg[2:0] : 3'h0].end_value;
        seg_t = esc[(seg_reg < 7'(`SWG_NUM_SEGS)) ? seg_reg[2:0] : 3'h0].time_ticks;
      end
      SWG_MODE_RAMP: begin
        seg_last = seg_reg == 7'h01;
        seg_s = i_ramp.start_value;
        seg_e = (seg_reg == 7'h00) ? i_ramp.start_value : i_ramp.end_value;
        seg_t = (seg_reg == 7'h00) ? i_ramp.t1 : i_ramp.t2;
      end
      default: begin
        seg_last = seg_reg == i_arb_end;
        seg_s = pt.linear_start_value;
        seg_e = pt.linear_end_value;
        seg_t = pt.time_ticks;
      end
    endcase
    if (state_reg == SWG_ST_PAUSE) begin
      seg_t = i_esc_pause;
    end
    if (seg_t == 29'h0) begin
      seg_t = 29'h1;
    end
    cfg_ok = (i_mode != SWG_MODE_ARB) || (i_arb_start >= 7'h01 &&
             i_arb_start <= i_arb_end && i_arb_end <= 7'(`SWG_NUM_PTS));
  end
  assign o_cfg_error = i_start && !cfg_ok && state_reg == SWG_ST_IDLE;

  // ==========================================
  // sequencer
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= SWG_ST_IDLE;
      seg_reg <= 7'h00;
      el_reg <= 29'h0;
      cyc_reg <= 10'h000;
      hold_reg <= 29'h0;
      zero_reg <= 1'b0;
      on_reg <= 1'b0;
      tgt_reg <= 1'b0;
    end else if (i_alarm || i_off) begin
      state_reg <= SWG_ST_IDLE;
      on_reg <= 1'b0;
    end else if (i_stop) begin
      state_reg <= SWG_ST_IDLE;
    end else begin
      case (state_reg)
        SWG_ST_IDLE: begin
          if (i_start && cfg_ok) begin
            state_reg <= SWG_ST_RUN;
            on_reg <= 1'b1;
            zero_reg <= 1'b0;
            tgt_reg <= (i_mode == SWG_MODE_ESC) ? 1'b0 : i_target_current;
            seg_reg <= (i_mode == SWG_MODE_ARB) ? i_arb_start : 7'h00;
            el_reg <= 29'h0;
            cyc_reg <= 10'h000;
          end
        end
        SWG_ST_RUN: begin
          if (tick && el_reg + 29'h1 >= seg_t) begin
            el_reg <= 29'h0;
            if (!seg_last) begin
              seg_reg <= seg_reg + 7'h01;
            end else begin
              case (i_mode)
                SWG_MODE_TRAP: seg_reg <= 7'h00;
                SWG_MODE_ESC: begin
                  if (i_esc_cycles == 10'h000 || cyc_reg + 10'h001 < i_esc_cycles) begin
                    cyc_reg <= cyc_reg + 10'h001;
                    seg_reg <= 7'h00;
                    state_reg <= (i_esc_cycles != 10'h001) ? SWG_ST_PAUSE : SWG_ST_RUN;
                  end else begin
                    state_reg <= SWG_ST_IDLE;
                  end
                end
                SWG_MODE_RAMP: begin
                  state_reg <= SWG_ST_HOLD;
                  hold_reg <= 29'h0;
                end
                default: begin
                  if (i_arb_cycles == 10'h000 || cyc_reg + 10'h001 < i_arb_cycles) begin
                    cyc_reg <= cyc_reg + 10'h001;
                    seg_reg <= i_arb_start;
                  end else begin
                    state_reg <= SWG_ST_IDLE;
                  end
                end
              endcase
            end
          end else if (tick) begin
            el_reg <= el_reg + 29'h1;
          end
        end
        SWG_ST_PAUSE: begin
          if (tick && el_reg + 29'h1 >= seg_t) begin
            el_reg <= 29'h0;
            state_reg <= SWG_ST_RUN;
          end else if (tick) begin
            el_reg <= el_reg + 29'h1;
          end
        end
        SWG_ST_HOLD: begin
          if (tick && hold_reg + 29'h1 >= 29'(AUTOSTOP_TICKS)) begin
            state_reg <= SWG_ST_IDLE;
            zero_reg <= 1'b1;
          end else if (tick) begin
            hold_reg <= hold_reg + 29'h1;
          end
        end
        default: state_reg <= SWG_ST_IDLE;
      endcase
    end
  end
  assign o_running = state_reg != SWG_ST_IDLE;
  assign o_output_on = on_reg;
  assign o_target_current = tgt_reg;

  // ==========================================
  // elapsed / time fraction divider, started the cycle after each tick
  logic [29:0] rem_reg;
  logic [28:0] den_reg;
  logic [15:0] quo_reg;
  logic [15:0] frac_reg;
  logic [4:0] div_cnt_reg;
  logic [29:0] rem_sh;
  logic ge;
  logic upd;
  assign rem_sh = {rem_reg[28:0], 1'b0};
  assign ge = rem_sh >= {1'b0, den_reg};
  assign upd = div_cnt_reg == 5'h01;
  // fraction lands in frac_reg with upd, so set point uses it one cycle later
  logic upd_d_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      upd_d_reg <= 1'b0;
    end else begin
      upd_d_reg <= upd;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rem_reg <= 30'h0;
      den_reg <= 29'h1;
      quo_reg <= 16'h0000;
      frac_reg <= 16'h0000;
      div_cnt_reg <= 5'h00;
    end else if (tick_d_reg) begin
      rem_reg <= {1'b0, el_reg};
      den_reg <= seg_t;
      div_cnt_reg <= 5'h10;
    end else if (div_cnt_reg != 5'h00) begin
      rem_reg <= ge ? rem_sh - {1'b0, den_reg} : rem_sh;
      quo_reg <= {quo_reg[14:0], ge};
      if (upd) begin
        frac_reg <= {quo_reg[14:0], ge};
      end
      div_cnt_reg <= div_cnt_reg - 5'h01;
    end
  end

  // ==========================================
  // set point arithmetic
  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] f);
    logic signed [16:0] d;
    logic signed [34:0] p;
    logic signed [34:0] r;
    d = $signed({1'b0, b}) - $signed({1'b0, a});
    p = d * $signed({1'b0, f});
    r = $signed({19'h0, a}) + (p >>> 16);
    return r[15:0];
  endfunction

  function automatic logic [7:0] sin_mag(input logic [3:0] i);
    case (i)
      4'h0: return 8'h0c;
      4'h1: return 8'h25;
      4'h2: return 8'h3e;
      4'h3: return 8'h56;
      4'h4: return 8'h6d;
      4'h5: return 8'h83;
      4'h6: return 8'h98;
      4'h7: return 8'hab;
      4'h8: return 8'hbd;
      4'h9: return 8'hcd;
      4'ha: return 8'hdb;
      4'hb: return 8'he7;
      4'hc: return 8'hf0;
      4'hd: return 8'hf7;
      4'he: return 8'hfc;
      default: return 8'hff;
    endcase
  endfunction

  logic [21:0] ph_reg;
  logic [21:0] ph_use;
  logic [21:0] ph_sum;
  logic [22:0] ph_wide;
  logic [15:0] f_int;
  logic [15:0] a_int;
  logic [7:0] idx;
  logic [23:0] ac_p;
  logic signed [18:0] total;
  logic [15:0] lin;
  logic [28:0] idx_p;
  always_comb begin
    lin = lerp(seg_s, seg_e, frac_reg);
    f_int = lerp({2'b00, pt.sine_start_frequency}, {2'b00, pt.sine_end_frequency}, frac_reg);
    a_int = lerp(pt.sine_start_amplitude, pt.sine_end_amplitude, frac_reg);
    ph_use = (el_reg == 29'h0) ? 22'(pt.angle) * `SWG_PHASE_DEG : ph_reg;
    // one bit of headroom: phase plus a full-rate step can pass 22 bits
    ph_wide = 23'(ph_use) + 23'(f_int) * 23'(`SWG_PHASE_STEP);
    if (ph_wide >= 23'(`SWG_PHASE_FULL)) begin
      ph_wide = ph_wide - 23'(`SWG_PHASE_FULL);
    end
    ph_sum = ph_wide[21:0];
    idx_p = 29'(ph_use) * `SWG_IDX_MUL;
    idx = idx_p[27:20];
    ac_p = a_int * sin_mag(idx[6] ? ~idx[5:2] : idx[5:2]);
    if (pt.sine_start_frequency == 14'h0 && pt.sine_end_frequency == 14'h0) begin
      ac_p = 24'h0;
    end
    total = $signed({3'b000, lin}) + (idx[7] ? -$signed({3'b000, ac_p[23:8]}) :
                                               $signed({3'b000, ac_p[23:8]}));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_reg <= 22'h0;
    end else if (upd_d_reg && state_reg == SWG_ST_RUN) begin
      ph_reg <= ph_sum;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_setpoint <= 16'h0000;
    end else if (!on_reg || zero_reg) begin
      o_setpoint <= 16'h0000;
    end else if (state_reg == SWG_ST_IDLE) begin
      o_setpoint <= i_static;
    end else if (state_reg == SWG_ST_HOLD && upd_d_reg) begin
      o_setpoint <= (i_ramp.end_value > i_nominal) ? i_nominal : i_ramp.end_value;
    end else if (upd_d_reg && state_reg == SWG_ST_RUN) begin
      if (i_mode != SWG_MODE_ARB) begin
        o_setpoint <= (lin > i_nominal) ? i_nominal : lin;
      end else if (total < 0) begin
        o_setpoint <= 16'h0000;
      end else if (total > $signed({3'b000, i_nominal})) begin
        o_setpoint <= i_nominal;
      end else begin
        o_setpoint <= total[15:0];
      end
    end
  end
endmodule // swg_gen

/* File: swg_gen_props.sv */
/*
 * concurrent checks on the set-point generator ports.
 * assumes one clock domain and the async active-low reset.
 */
module swg_gen_props
  import swg_pkg::*;
#(
  parameter int AUTOSTOP_TICKS = 50
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire swg_mode_t i_mode,
  input wire logic [15:0] i_nominal,
  input wire logic [6:0] i_arb_start,
  input wire logic [6:0] i_arb_end,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_off,
  input wire logic i_alarm,
  input wire logic [15:0] o_setpoint,
  input wire logic o_target_current,
  input wire logic o_output_on,
  input wire logic o_running,
  input wire logic o_tick,
  input wire logic o_cfg_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // tick spacing helper
  logic [11:0] tick_cnt_reg;
  logic tick_seen_reg;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_reg <= 12'h0;
      tick_seen_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= o_tick ? 12'h0 : tick_cnt_reg + 12'h1;
      tick_seen_reg <= tick_seen_reg | o_tick;
    end
  end
  // ==========================================
  // assertions
  a_tick_period: assert property (o_tick && tick_seen_reg |-> tick_cnt_reg == 12'hf9f)
    else $error("tick spacing wrong");
  a_upd_on_tick: assert property (o_running && $changed(o_setpoint) && !$rose(o_running)
    |-> $past(o_tick, 19))
    else $error("set point moved off the tick slot");
  a_alarm_off: assert property (i_alarm || i_off |-> ##[1:2] !o_output_on)
    else $error("output stayed on after abort");
  a_alarm_zero: assert property (i_alarm |-> ##[1:2] (o_setpoint == 16'h0 && !o_running))
    else $error("set point not zeroed after alarm");
  a_bad_index: assert property (i_start && !o_running && i_mode == SWG_MODE_ARB &&
    (i_arb_start == 7'h0 || i_arb_start > i_arb_end || i_arb_end > 7'h63) |-> o_cfg_error)
    else $error("bad block indices accepted");
  a_cfg_refuse: assert property (o_cfg_error |=> !o_running)
    else $error("refused start still ran");
  a_start_runs: assert property (i_start && !o_running && !i_alarm && !i_off && !i_stop &&
    !o_cfg_error |=> o_running && o_output_on)
    else $error("start not taken");
  a_esc_voltage: assert property ($rose(o_running) && $past(i_mode) == SWG_MODE_ESC
    |-> !o_target_current)
    else $error("engine-start drove current");
  a_in_range: assert property (o_setpoint <= i_nominal)
    else $error("set point above nominal");
  c_trap_run: cover property (o_running && i_mode == SWG_MODE_TRAP && o_tick);
  c_alarm: cover property (o_running && i_alarm);
  c_cfg_err: cover property (o_cfg_error);
endmodule // swg_gen_props

bind swg_gen swg_gen_props #(.AUTOSTOP_TICKS(AUTOSTOP_TICKS)) u_props (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_mode(i_mode), .i_nominal(i_nominal),
  .i_arb_start(i_arb_start), .i_arb_end(i_arb_end), .i_start(i_start), .i_stop(i_stop),
  .i_off(i_off), .i_alarm(i_alarm), .o_setpoint(o_setpoint),
  .o_target_current(o_target_current), .o_output_on(o_output_on),
  .o_running(o_running), .o_tick(o_tick), .o_cfg_error(o_cfg_error));

/* File: swg_loop_model.sv */
/*
 * regulation loop model: applies the set point while the output is on.
 * assumes set point and enable are registers of the generator clock.
 */
module swg_loop_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [15:0] i_setpoint,
  input wire logic i_output_on,
  output logic [15:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // regulated level follows the set point, zero when output off
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_level <= 16'h0;
    end else begin
      o_level <= i_output_on ? i_setpoint : 16'h0;
    end
  end
endmodule // swg_loop_model

/* File: swg_pkg.sv */
/*
 * types of the set-point waveform generator.
 * assumes nothing beyond swg_regs.svh.
 */
package swg_pkg;
  typedef enum logic [1:0] {
    SWG_MODE_TRAP = 2'h0,
    SWG_MODE_ESC = 2'h1,
    SWG_MODE_RAMP = 2'h2,
    SWG_MODE_ARB = 2'h3
  } swg_mode_t;
  typedef enum logic [3:0] {
    SWG_ST_IDLE = 4'h1,
    SWG_ST_RUN = 4'h2,
    SWG_ST_PAUSE = 4'h4,
    SWG_ST_HOLD = 4'h8
  } swg_state_t;
  typedef struct packed {
    logic [15:0] offset;
    logic [15:0] amplitude;
    logic [28:0] t1;
    logic [28:0] t2;
    logic [28:0] t3;
    logic [28:0] t4;
  } swg_trap_t;
  typedef struct packed {
    logic [15:0] start_value;
    logic [15:0] end_value;
    logic [28:0] t1;
    logic [28:0] t2;
  } swg_ramp_t;
  typedef struct packed {
    logic [15:0] start_value;
    logic [15:0] end_value;
    logic [28:0] time_ticks;
  } swg_seg_t;
  typedef struct packed {
    logic [15:0] sine_start_amplitude;
    logic [15:0] sine_end_amplitude;
    logic [13:0] sine_start_frequency;
    logic [13:0] sine_end_frequency;
    logic [8:0] angle;
    logic [15:0] linear_start_value;
    logic [15:0] linear_end_value;
    logic [28:0] time_ticks;
  } swg_point_t;
endpackage

/* File: swg_regs.svh */
/*
 * constants of the set-point waveform generator: tick timing, limits,
 * engine-start defaults.
 * assumes a 40 MHz system clock and times given in 0.1 ms ticks.
 */
`ifndef SWG_REGS_SVH
`define SWG_REGS_SVH
// ==========================================
// timing
`define SWG_CLK_HZ 40000000
`define SWG_TICK_NS 100000
`define SWG_TICK_CYC (`SWG_TICK_NS / 1000 * (`SWG_CLK_HZ / 1000000))
`define SWG_TICKS_PER_S 10000
`define SWG_AUTOSTOP_S 36000
`define SWG_AUTOSTOP_TICKS (`SWG_AUTOSTOP_S * `SWG_TICKS_PER_S)
`define SWG_TIME_MAX 29'd360000000
`define SWG_PT_DEF_TIME 29'd10
// ==========================================
// limits
`define SWG_FREQ_MAX 14'd10000
`define SWG_ANGLE_MAX 9'd359
`define SWG_NUM_PTS 99
`define SWG_NUM_SEGS 5
`define SWG_DF_SCALE 40'd100000
`define SWG_DF_MIN 40'd93
`define SWG_PHASE_FULL 22'd3600000
`define SWG_PHASE_DEG 22'd10000
`define SWG_PHASE_STEP 22'd360
`define SWG_IDX_MUL 29'd74
// ==========================================
// engine-start defaults: start, end, time in ticks
`define SWG_ESC_DEF0 {16'h8000, 16'h3000, 29'd150}
`define SWG_ESC_DEF1 {16'h3000, 16'h5000, 29'd200}
`define SWG_ESC_DEF2 {16'h5000, 16'h5000, 29'd5000}
`define SWG_ESC_DEF3 {16'h5000, 16'h8000, 29'd1000}
`define SWG_ESC_DEF4 {16'h8000, 16'h8000, 29'd1000}
`endif

/* File: tb_top.sv */
/*
 * self-checking bench of the set-point generator.
 * assumes a 40 MHz clock, short autostop and the loop model.
 */
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
`include "swg_regs.svh"
module tb_top
  import swg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam swg_seg_t ESC0 = `SWG_ESC_DEF0;
  logic i_clk_sys, i_rst_b, i_target_current, i_esc_wr, i_pt_wr;
  logic i_start, i_stop, i_off, i_alarm;
  swg_mode_t i_mode;
  logic [15:0] i_nominal, i_static, o_setpoint, level;
  swg_trap_t i_trap;
  swg_ramp_t i_ramp;
  logic [9:0] i_esc_cycles, i_arb_cycles;
  logic [28:0] i_esc_pause;
  logic [2:0] i_esc_idx;
  swg_seg_t i_esc_data;
  logic [6:0] i_arb_start, i_arb_end, i_pt_idx;
  swg_point_t i_pt_data;
  logic o_target_current, o_output_on, o_running, o_tick, o_wr_reject, o_cfg_error;
  int miscompares = 0;
  int compares = 0;
  logic [15:0] s [9];
  logic [15:0] trap_exp [5] = '{16'h1000, 16'h1800, 16'h2000, 16'h2000, 16'h1000};
  int k;
  swg_gen #(.AUTOSTOP_TICKS(5)) DUT (.*);
  swg_loop_model u_loop (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_setpoint(o_setpoint),
    .i_output_on(o_output_on), .o_level(level));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // ==========================================
  // tasks
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic go(input swg_mode_t m);
    @(posedge i_clk_sys) begin i_mode <= m; i_start <= 1'b1; end
    @(posedge i_clk_sys) i_start <= 1'b0;
  endtask
  task automatic pulse_stop(input logic alarm);
    @(posedge i_clk_sys) begin i_stop <= !alarm; i_alarm <= alarm; end
    @(posedge i_clk_sys) begin i_stop <= 1'b0; i_alarm <= 1'b0; end
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic sample(output logic [15:0] v);
    for (int n = 0; n < 5000 && o_tick !== 1'b1; n++) @(negedge i_clk_sys);
    repeat (20) @(negedge i_clk_sys);
    v = o_setpoint;
  endtask
  task automatic wr_pt(input logic [6:0] idx, input swg_point_t d, input logic rej);
    @(posedge i_clk_sys) begin i_pt_wr <= 1'b1; i_pt_idx <= idx; i_pt_data <= d; end
    @(negedge i_clk_sys) `CHK(o_wr_reject, rej)
    @(posedge i_clk_sys) i_pt_wr <= 1'b0;
  endtask
  // ==========================================
  // tests
  initial begin
    i_rst_b = 1'b0; i_mode = SWG_MODE_TRAP; i_target_current = 1'b0; i_nominal = 16'hc000;
    i_static = 16'h0400; i_trap = '{16'h1000, 16'h1000, 29'd2, 29'd1, 29'd1, 29'd1};
    i_ramp = '{16'h0400, 16'h0800, 29'd1, 29'd2}; i_esc_cycles = 10'd1; i_esc_pause = 29'd1;
    i_esc_wr = 1'b0; i_esc_idx = 3'h0; i_esc_data = '{16'h0, 16'h0, 29'd1};
    i_arb_start = 7'h2; i_arb_end = 7'h1; i_arb_cycles = 10'd1; i_pt_wr = 1'b0;
    i_pt_idx = 7'h1; i_pt_data = '0; i_start = 1'b0; i_stop = 1'b0; i_off = 1'b0;
    i_alarm = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    // trapezoid phases, levels and period
    go(SWG_MODE_TRAP);
    #1 `CHK(o_running, 1'b1)
    for (int i = 0; i < 9; i++) sample(s[i]);
    k = -1;
    for (int i = 4; i >= 0; i--) if (s[i] === 16'h1000 && s[i + 1] === 16'h1800) k = i;
    `CHK(k >= 0, 1'b1)
    if (k >= 0) for (int j = 0; j < 5; j++) `CHK(s[k + j], trap_exp[j])
    for (int i = 0; i < 4; i++) `CHK(s[i + 5], s[i])
    pulse_stop(1'b1);
    `CHK({o_output_on, o_running, o_setpoint, level}, 34'h0)
    // engine-start: voltage only, preloaded first segment
    @(posedge i_clk_sys) begin i_esc_wr <= 1'b1; i_esc_idx <= 3'h5; end
    @(negedge i_clk_sys) `CHK(o_wr_reject, 1'b1)
    @(posedge i_clk_sys) begin i_esc_wr <= 1'b0; i_target_current <= 1'b1; end
    go(SWG_MODE_ESC);
    #1 `CHK(o_target_current, 1'b0)
    sample(s[0]);
    // first update is elapsed tick 1 of segment 0, Q16 fraction
    k = int'(ESC0.start_value) + (((int'(ESC0.end_value) - int'(ESC0.start_value))
        * (65536 / int'(ESC0.time_ticks))) >>> 16);
    `CHK(s[0], 16'(k))
    pulse_stop(1'b0);
    `CHK({o_output_on, o_running, o_setpoint}, {2'b10, 16'h0400})
    @(posedge i_clk_sys) i_target_current <= 1'b0;
    // ramp: delay, slope, hold, autostop
    go(SWG_MODE_RAMP);
    for (int i = 0; i < 5; i++) sample(s[i]);
    `CHK({s[0], s[1], s[2]}, {16'h0400, 16'h0600, 16'h0800})
    `CHK({s[3], s[4]}, {16'h0800, 16'h0800})
    for (int n = 0; n < 40000 && o_running === 1'b1; n++) @(negedge i_clk_sys);
    repeat (2) @(negedge i_clk_sys);
    `CHK({o_running, o_setpoint}, 17'h0)
    // arbitrary: point writes, refusals, flat dc point
    wr_pt(7'h1, '{16'h0, 16'h0, 14'd0, 14'd0, 9'd360, 16'h0300, 16'h0300, 29'd2}, 1'b1);
    wr_pt(7'h1, '{16'h0, 16'h0, 14'd10001, 14'd0, 9'd0, 16'h0300, 16'h0300, 29'd2}, 1'b1);
    wr_pt(7'h1, '{16'h0, 16'h0, 14'd10, 14'd11, 9'd0, 16'h0300, 16'h0300, 29'd10000}, 1'b1);
    wr_pt(7'h1, '{16'h0200, 16'h0200, 14'd0, 14'd0, 9'd0, 16'h0100, 16'h0300, 29'd2}, 1'b1);
    wr_pt(7'h1, '{16'h0, 16'h0, 14'd0, 14'd0, 9'd0, 16'h0300, 16'h0300, 29'd0}, 1'b1);
    wr_pt(7'h1, '{16'h0, 16'h0, 14'd0, 14'd0, 9'd0, 16'h0300, 16'h0300, 29'd2}, 1'b0);
    @(posedge i_clk_sys) begin i_mode <= SWG_MODE_ARB; i_start <= 1'b1; end
    @(negedge i_clk_sys) `CHK(o_cfg_error, 1'b1)
    @(posedge i_clk_sys) begin
      i_start <= 1'b0;
      i_arb_start <= 7'h1;
      i_arb_cycles <= 10'd2;
      i_target_current <= 1'b1;
    end
    #1 `CHK(o_running, 1'b0)
    go(SWG_MODE_ARB);
    #1 `CHK(o_target_current, 1'b1)
    sample(s[0]);
    sample(s[1]);
    `CHK({s[0], s[1]}, {16'h0300, 16'h0300})
    for (int n = 0; n < 12000 && o_running === 1'b1; n++) @(negedge i_clk_sys);
    repeat (2) @(negedge i_clk_sys);
    `CHK({o_running, o_setpoint}, {1'b0, 16'h0400})
    report_and_stop();
  end
  initial begin
    #3ms;
    miscompares++;
    report_and_stop();
  end
endmodule // tb_top
